/* common/sidms_pkg.sv */
package sidms_pkg;

   // Instruction byte layout.
   localparam int INSTR_BITS = 8;
   localparam int DIR_POS = 7;
   localparam int ADDR_MSB = 4;
   localparam int ADDR_W = 5;

   // Control function one layout and reset value.
   localparam int CTRL_W = 32;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int RAM_POWER_POS = 31;
   localparam int SWEEP_MODE_POS = 21;
   localparam int LOW_BYTE_MSB = 7;
   localparam int LOW_BYTE_LSB = 1;

   // Serial addresses.
   localparam logic [4:0] ADDR_CTRL_ONE = 5'h00;
   localparam logic [4:0] ADDR_CTRL_TWO = 5'h01;
   localparam logic [4:0] ADDR_AMP_SCALE = 5'h02;
   localparam logic [4:0] ADDR_FREQ_WORD = 5'h04;
   localparam logic [4:0] ADDR_REMAP_LO = 5'h07;
   localparam logic [4:0] ADDR_REMAP_HI = 5'h0A;

   // Register widths in bytes.
   localparam logic [2:0] BYTES_CTRL_ONE = 3'h4;
   localparam logic [2:0] BYTES_CTRL_TWO = 3'h3;
   localparam logic [2:0] BYTES_AMP_SCALE = 3'h2;
   localparam logic [2:0] BYTES_FREQ_WORD = 3'h4;
   localparam logic [2:0] BYTES_SEGMENT = 3'h4;
   localparam logic [2:0] BYTES_SWEEP = 3'h4;
   localparam logic [2:0] BYTES_DEFAULT = 3'h4;

   localparam int SYNC_STAGES = 2;

   typedef enum logic {LINK_INSTR, LINK_DATA} sidms_link_state_t;

   typedef struct packed {
      logic read;
      logic [4:0] addr;
      logic sweep_map;
   } sidms_instr_t;

   typedef struct packed {
      logic digital_pd;
      logic comparator_pd;
      logic converter_pd;
      logic clock_input_pd;
      logic external_pd_mode;
      logic sweep_no_dwell;
      logic sync_clk_out_disable;
   } sidms_power_t;

   function automatic logic is_remapped(input logic [4:0] addr);
      return (addr >= ADDR_REMAP_LO) && (addr <= ADDR_REMAP_HI);
   endfunction

   function automatic logic [2:0] byte_count(input logic [4:0] addr, input logic sweep_map);
      logic [2:0] n;
      n = BYTES_DEFAULT;
      if (is_remapped(addr)) begin
         n = sweep_map ? BYTES_SWEEP : BYTES_SEGMENT;
      end else if (addr == ADDR_CTRL_ONE) begin
         n = BYTES_CTRL_ONE;
      end else if (addr == ADDR_CTRL_TWO) begin
         n = BYTES_CTRL_TWO;
      end else if (addr == ADDR_AMP_SCALE) begin
         n = BYTES_AMP_SCALE;
      end else if (addr == ADDR_FREQ_WORD) begin
         n = BYTES_FREQ_WORD;
      end
      return n;
   endfunction

endpackage

/* src/sidms_top.sv */
`timescale 1ns/100ps
`default_nettype none
module sidms_top (
   input wire logic sys_clk, // System clock, 100 MHz.
   input wire logic resetn, // Asynchronous reset, active low.
   input wire logic sclk, // Serial clock from the controller.
   input wire logic cs_n, // Chip select, active low.
   input wire logic sdio_in, // Serial data pin, input side.
   output logic sdio_out, // Serial data pin, output side.
   output logic sdio_oe, // Serial data pin output enable.
   input wire logic port_resync, // Port resync, active high.
   output logic instr_valid, // One-cycle pulse on each decoded instruction.
   output sidms_pkg::sidms_instr_t instr_info, // Last decoded instruction.
   output logic sel_ram_segment_word, // Decoded access targets a segment word.
   output logic sel_sweep_word, // Decoded access targets a sweep word.
   output sidms_pkg::sidms_power_t power_ctrl, // Control one bits 7 to 1.
   output logic sweep_active, // Linear sweep behaviour active.
   output logic ram_active, // RAM-driven behaviour active.
   output logic ram_power // RAM powered.
);

   // Resync aborts only the port sequencer; control one sits on resetn alone.
   logic link_rst_n;
   assign link_rst_n = resetn & ~port_resync;

   // Link domain state.
   sidms_pkg::sidms_link_state_t state_reg, state_next;
   logic [5:0] cnt_reg, cnt_next;
   logic [6:0] instr_sh_reg, instr_sh_next;
   logic [31:0] wr_sh_reg, wr_sh_next;
   logic [31:0] rd_sh_reg, rd_sh_next;
   logic [5:0] bits_reg, bits_next;
   sidms_pkg::sidms_instr_t hold_reg, hold_next;
   logic tog_reg, tog_next;
   logic ctrl_tog_reg, ctrl_tog_next;
   logic [31:0] ctrl_reg, ctrl_next;
   logic [7:0] new_byte;
   logic [31:0] new_word;

   assign new_byte = {instr_sh_reg, sdio_in};
   assign new_word = {wr_sh_reg[30:0], sdio_in};

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      instr_sh_next = instr_sh_reg;
      wr_sh_next = wr_sh_reg;
      rd_sh_next = rd_sh_reg;
      bits_next = bits_reg;
      hold_next = hold_reg;
      tog_next = tog_reg;
      ctrl_tog_next = ctrl_tog_reg;
      ctrl_next = ctrl_reg;
      // A high chip select suspends the cycle where it stands.
      if (!cs_n) begin
         unique case (state_reg)
            sidms_pkg::LINK_INSTR: begin
               instr_sh_next = new_byte[6:0];
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == 6'(sidms_pkg::INSTR_BITS - 1)) begin
                  hold_next.read = new_byte[sidms_pkg::DIR_POS];
                  hold_next.addr = new_byte[sidms_pkg::ADDR_MSB:0];
                  hold_next.sweep_map = ctrl_reg[sidms_pkg::SWEEP_MODE_POS];
                  bits_next = {sidms_pkg::byte_count(new_byte[sidms_pkg::ADDR_MSB:0],
                     ctrl_reg[sidms_pkg::SWEEP_MODE_POS]), 3'h0};
                  rd_sh_next = (new_byte[sidms_pkg::ADDR_MSB:0] == sidms_pkg::ADDR_CTRL_ONE) ?
                     ctrl_reg : 32'h0000_0000;
                  tog_next = ~tog_reg;
                  cnt_next = 6'h00;
                  state_next = sidms_pkg::LINK_DATA;
               end
            end
            sidms_pkg::LINK_DATA: begin
               wr_sh_next = new_word;
               rd_sh_next = {rd_sh_reg[30:0], 1'b0};
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == bits_reg - 6'h01) begin
                  if (!hold_reg.read && hold_reg.addr == sidms_pkg::ADDR_CTRL_ONE) begin
                     ctrl_next = new_word;
                     ctrl_tog_next = ~ctrl_tog_reg;
                  end
                  cnt_next = 6'h00;
                  state_next = sidms_pkg::LINK_INSTR;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_reg <= sidms_pkg::LINK_INSTR;
         cnt_reg <= 6'h00;
         instr_sh_reg <= 7'h00;
         wr_sh_reg <= 32'h0000_0000;
         rd_sh_reg <= 32'h0000_0000;
         bits_reg <= 6'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         instr_sh_reg <= instr_sh_next;
         wr_sh_reg <= wr_sh_next;
         rd_sh_reg <= rd_sh_next;
         bits_reg <= bits_next;
      end
   end

   // The handoff word and toggle survive resync so a pending handoff is not torn.
   always_ff @(posedge sclk or negedge resetn) begin
      if (!resetn) begin
         hold_reg <= '0;
         tog_reg <= 1'b0;
         ctrl_tog_reg <= 1'b0;
         ctrl_reg <= sidms_pkg::CTRL_RESET;
      end else begin
         hold_reg <= hold_next;
         tog_reg <= tog_next;
         ctrl_tog_reg <= ctrl_tog_next;
         ctrl_reg <= ctrl_next;
      end
   end

   // Read data leaves on the falling edge so it is stable at the next rising one.
   always_ff @(negedge sclk or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sdio_out <= 1'b0;
         sdio_oe <= 1'b0;
      end else begin
         sdio_out <= rd_sh_reg[31];
         sdio_oe <= !cs_n && state_reg == sidms_pkg::LINK_DATA && hold_reg.read;
      end
   end

   // System domain. Control one crosses under its own toggle handshake, so bits changed
   // by one write are taken together and never show a mixed state on this side.
   logic [8:0] lvl_s2_reg, lvl_next;
   logic [2:0] tog_s_reg;
   logic [2:0] ctrl_tog_s_reg;
   logic instr_valid_next, sel_seg_next, sel_sweep_next, sweep_next, ram_act_next;
   sidms_pkg::sidms_instr_t info_next;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         lvl_s2_reg <= 9'h000;
         tog_s_reg <= 3'h0;
         ctrl_tog_s_reg <= 3'h0;
      end else begin
         lvl_s2_reg <= lvl_next;
         tog_s_reg <= {tog_s_reg[1:0], tog_reg};
         ctrl_tog_s_reg <= {ctrl_tog_s_reg[1:0], ctrl_tog_reg};
      end
   end

   // The handoff word is read at least eight serial edges before it can change again.
   // Control one is likewise read only after its toggle has settled here.
   always_comb begin
      instr_valid_next = tog_s_reg[2] ^ tog_s_reg[1];
      lvl_next = lvl_s2_reg;
      if (ctrl_tog_s_reg[2] ^ ctrl_tog_s_reg[1]) begin
         lvl_next = {ctrl_reg[sidms_pkg::RAM_POWER_POS], ctrl_reg[sidms_pkg::SWEEP_MODE_POS],
            ctrl_reg[sidms_pkg::LOW_BYTE_MSB:sidms_pkg::LOW_BYTE_LSB]};
      end
      info_next = instr_info;
      sel_seg_next = sel_ram_segment_word;
      sel_sweep_next = sel_sweep_word;
      if (instr_valid_next) begin
         info_next = hold_reg;
         sel_seg_next = sidms_pkg::is_remapped(hold_reg.addr) && !hold_reg.sweep_map;
         sel_sweep_next = sidms_pkg::is_remapped(hold_reg.addr) && hold_reg.sweep_map;
      end
      sweep_next = lvl_s2_reg[7];
      ram_act_next = lvl_s2_reg[8] && !lvl_s2_reg[7];
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         instr_valid <= 1'b0;
         instr_info <= '0;
         sel_ram_segment_word <= 1'b0;
         sel_sweep_word <= 1'b0;
         power_ctrl <= '0;
         sweep_active <= 1'b0;
         ram_active <= 1'b0;
         ram_power <= 1'b0;
      end else begin
         instr_valid <= instr_valid_next;
         instr_info <= info_next;
         sel_ram_segment_word <= sel_seg_next;
         sel_sweep_word <= sel_sweep_next;
         power_ctrl <= lvl_s2_reg[6:0];
         sweep_active <= sweep_next;
         ram_active <= ram_act_next;
         ram_power <= lvl_s2_reg[8];
      end
   end

   // Checks on the serial side.
   chk_dir_capture: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (!cs_n && state_reg == sidms_pkg::LINK_INSTR && cnt_reg == 6'h07)
      |=> hold_reg.read == $past(instr_sh_reg[6]))
      else $error("direction bit not captured");
   chk_addr_capture: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (!cs_n && state_reg == sidms_pkg::LINK_INSTR && cnt_reg == 6'h07)
      |=> hold_reg.addr == {$past(instr_sh_reg[3:0]), $past(sdio_in)})
      else $error("address not captured");
   chk_dontcare_bits: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (state_reg == sidms_pkg::LINK_DATA)
      |-> bits_reg == {sidms_pkg::byte_count(hold_reg.addr, hold_reg.sweep_map), 3'h0})
      else $error("length depends on ignored bits");
   chk_map_select: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (!cs_n && state_reg == sidms_pkg::LINK_INSTR && cnt_reg == 6'h07)
      |=> hold_reg.sweep_map == $past(ctrl_reg[sidms_pkg::SWEEP_MODE_POS]))
      else $error("map not taken from sweep bit");
   chk_instr_eight: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (!cs_n && state_reg == sidms_pkg::LINK_INSTR && cnt_reg == 6'h00) ##1 (!cs_n)[*6]
      |=> state_reg == sidms_pkg::LINK_INSTR && cnt_reg == 6'h07)
      else $error("instruction not eight edges");
   chk_data_end: assert property (@(posedge sclk) disable iff (!link_rst_n)
      (!cs_n && state_reg == sidms_pkg::LINK_DATA && cnt_reg == bits_reg - 6'h01)
      |=> state_reg == sidms_pkg::LINK_INSTR && cnt_reg == 6'h00)
      else $error("data phase length wrong");
   // Checks on the system side.
   chk_remap_range: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(instr_valid) && !sidms_pkg::is_remapped(instr_info.addr)
      |-> !sel_ram_segment_word && !sel_sweep_word)
      else $error("remap outside 0x07 to 0x0A");
   chk_remap_target: assert property (@(posedge sys_clk) disable iff (!resetn)
      instr_valid && sidms_pkg::is_remapped(instr_info.addr)
      |-> sel_sweep_word == instr_info.sweep_map && sel_ram_segment_word != instr_info.sweep_map)
      else $error("remap target wrong");
   chk_sweep_priority: assert property (@(posedge sys_clk) disable iff (!resetn)
      sweep_active |-> !ram_active)
      else $error("RAM active during sweep");
   chk_ram_power: assert property (@(posedge sys_clk) disable iff (!resetn)
      $rose(lvl_s2_reg[8]) |=> ram_power ##0 sel_ram_segment_word == $past(sel_ram_segment_word)
      || instr_valid)
      else $error("RAM power wrong");
   cov_write_cycle: cover property (@(posedge sclk) disable iff (!link_rst_n)
      state_reg == sidms_pkg::LINK_DATA && !hold_reg.read ##1 state_reg == sidms_pkg::LINK_INSTR);
   cov_read_cycle: cover property (@(posedge sclk) disable iff (!link_rst_n)
      state_reg == sidms_pkg::LINK_DATA && hold_reg.read);
   cov_sweep_word: cover property (@(posedge sys_clk) disable iff (!resetn) sel_sweep_word);
   cov_segment_word: cover property (@(posedge sys_clk) disable iff (!resetn) sel_ram_segment_word);

endmodule // sidms_top
`default_nettype wire

/* testbench/sidms_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sidms_ctrl_model (
   output logic sclk, // Serial clock, still low between frames.
   output logic cs_n, // Chip select, active low.
   output logic sdio_in, // Data towards the device.
   input wire logic sdio_out, // Data from the device.
   input wire logic sdio_oe // Device drive enable.
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdio_in = 1'b0;
   end

   // Sends one frame of nedge rising edges, MSB first; data after the
   // instruction is taken on the rising edge, since the device launches it
   // on the falling edge before.
   task automatic frame(input logic [7:0] instr, input int nedge, input logic [31:0] wd,
                        output logic [31:0] rd, output int oe_cnt);
      logic [39:0] word;
      rd = 32'h0000_0000;
      oe_cnt = 0;
      word = {instr, wd << (40 - nedge)};
      #7.3;
      cs_n = 1'b0;
      for (int i = 0; i < nedge; i++) begin
         if (i < 8 || !instr[7]) begin
            sdio_in = word[39 - i];
         end else begin
            sdio_in = ~sdio_in;
         end
         #15 sclk = 1'b1;
         if (sdio_oe === 1'b1) begin
            oe_cnt++;
         end
         if (i >= 8) begin
            rd = {rd[30:0], sdio_out};
         end
         #15 sclk = 1'b0;
      end
      cs_n = 1'b1;
      // The line is let go here, so it must not keep showing the last bit.
      sdio_in = ~sdio_in;
   endtask
endmodule // sidms_ctrl_model
`default_nettype wire

/* testbench/serial_instruction_decode_and_map_select_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module serial_instruction_decode_and_map_select_tb;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic port_resync = 1'b0;
   wire logic sclk, cs_n, sdio_in, sdio_out, sdio_oe, instr_valid;
   wire logic sel_ram_segment_word, sel_sweep_word, sweep_active, ram_active, ram_power;
   sidms_pkg::sidms_instr_t instr_info;
   sidms_pkg::sidms_power_t power_ctrl;
   int bad_count = 0;
   int comparisons = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000_005E;
   logic [31:0] ctrl_model = 32'h0000_0000;
   logic [8:0] exp_q[$];

   always #5 sys_clk = ~sys_clk;

   sidms_top i_sidms_top (.sys_clk(sys_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .port_resync(port_resync),
      .instr_valid(instr_valid), .instr_info(instr_info),
      .sel_ram_segment_word(sel_ram_segment_word), .sel_sweep_word(sel_sweep_word),
      .power_ctrl(power_ctrl), .sweep_active(sweep_active), .ram_active(ram_active),
      .ram_power(ram_power));

   sidms_ctrl_model i_sidms_ctrl_model (.sclk(sclk), .cs_n(cs_n), .sdio_in(sdio_in),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_of_test();
      if (bad_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk_ctrl();
      @(negedge sys_clk);
      check("power_ctrl", 32'(power_ctrl), 32'(ctrl_model[7:1]));
      check("sweep_active", 32'(sweep_active), 32'(ctrl_model[21]));
      check("ram_power", 32'(ram_power), 32'(ctrl_model[31]));
      check("ram_active", 32'(ram_active), 32'(ctrl_model[31] & ~ctrl_model[21]));
   endtask

   // Map is taken from the control word as it stands before this frame.
   task automatic send(input logic [7:0] instr, input logic [31:0] wd, output logic [31:0] rd);
      logic [4:0] a;
      logic m;
      logic hit;
      int n;
      int oe;
      a = instr[4:0];
      m = ctrl_model[21];
      hit = (a >= 5'h07) && (a <= 5'h0A);
      n = (a == 5'h00) ? 32 : (a == 5'h01) ? 24 : (a == 5'h02) ? 16 : 32;
      exp_q.push_back({instr[7], a, m, !m && hit, m && hit});
      i_sidms_ctrl_model.frame(instr, 8 + n, wd, rd, oe);
      check("sdio_oe", 32'(oe), instr[7] ? 32'(n) : 32'h0000_0000);
      if (a == 5'h00 && !instr[7]) begin
         ctrl_model = wd;
      end
      repeat (12) @(posedge sys_clk);
   endtask

   always @(negedge sys_clk) begin
      if (instr_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("spare_instr", 32'h0000_0001, 32'h0000_0000);
         end else begin
            check("instr_info", 32'(instr_info), 32'(exp_q[0][8:2]));
            check("selects", 32'({sel_ram_segment_word, sel_sweep_word}),
               32'(exp_q[0][1:0]));
            void'(exp_q.pop_front());
         end
      end
   end

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end

   initial begin
      logic [31:0] r, v, rd;
      int oe;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      chk_ctrl();
      // The middle pass drops RAM power as sweep goes on; the last keeps both on.
      for (int p = 0; p < 3; p++) begin
         r = rnd();
         v = rnd();
         v[21] = (p != 0);
         v[31] = (p != 1);
         send({1'b0, r[6:5], 5'h00}, v, rd);
         chk_ctrl();
         send({1'b1, r[4:3], 5'h00}, rnd(), rd);
         check("ctrl_read", rd, ctrl_model);
         for (int k = 1; k < 13; k++) begin
            r = rnd();
            send({r[7:5], 5'(k)}, r, rd);
            if (r[7]) begin
               check("other_read", rd, 32'h0000_0000);
            end
         end
      end
      // Abort a write in mid data phase; the stored word must survive.
      exp_q.push_back({1'b0, 5'h00, ctrl_model[21], 2'b00});
      i_sidms_ctrl_model.frame(8'h00, 28, ~ctrl_model, rd, oe);
      check("abort_oe", 32'(oe), 32'h0000_0000);
      @(posedge sys_clk);
      port_resync <= 1'b1;
      repeat (4) @(posedge sys_clk);
      port_resync <= 1'b0;
      repeat (4) @(posedge sys_clk);
      send(8'h80, 32'h0000_0000, rd);
      check("resync_keep", rd, ctrl_model);
      chk_ctrl();
      repeat (20) @(posedge sys_clk);
      check("pending", 32'(exp_q.size()), 32'h0000_0000);
      end_of_test();
   end
endmodule // serial_instruction_decode_and_map_select_tb
`default_nettype wire
